// file: core/lrpf_cfg.svh
// constants for the receive phase recovery fifo: widths, rates, budgets
// assumes nothing; included by the package, the fifo top, the frequency limit module and every dv file
`ifndef LRPF_CFG_SVH
`define LRPF_CFG_SVH

// ***********************************************
// link and core geometry
// ***********************************************
`define LRPF_LINK_W 8
`define LRPF_LINK_MTS 1600
`define LRPF_CORE_MTS 200
`define LRPF_LINE_SLOTS (`LRPF_LINK_MTS / `LRPF_CORE_MTS)
`define LRPF_DEPTH 64

// ***********************************************
// separation budget, in transmit-rate slots except the sampling error (core clocks) and the async drift rate (ppm)
// ***********************************************
`define LRPF_DRIFT_SLOTS 2
`define LRPF_SKEW_CONST_SLOTS 1
`define LRPF_SKEW_VAR_SLOTS 1
`define LRPF_SAMPLE_ERR_RCLK 1
`define LRPF_SYNC_COMP_SLOTS 2
`define LRPF_ASYNC_PPM 2000

// ***********************************************
// frequency capability fields
// ***********************************************
`define LRPF_FREQ_W 4
`define LRPF_CAP_W 16

`endif

// file: core/lrpf_pkg.sv
// types shared by the receive phase recovery fifo and its helpers
// assumes lrpf_cfg.svh is on the include path
`include "lrpf_cfg.svh"

package lrpf_pkg;

   // clocking modes; code 2'h3 is unused and behaves like async
   typedef enum logic [1:0] {
      LRPF_MODE_SYNC = 2'h0,
      LRPF_MODE_PSEUDO = 2'h1,
      LRPF_MODE_ASYNC = 2'h2
   } lrpf_mode_e;

   // read side sequencing
   typedef enum logic [1:0] {
      LRPF_ST_IDLE = 2'h0,
      LRPF_ST_ARMED = 2'h1,
      LRPF_ST_RUN = 2'h2
   } lrpf_state_e;

   // one transmit-rate slot as stored in the fifo
   typedef struct packed {
      logic ctl;
      logic [`LRPF_LINK_W-1:0] data;
   } lrpf_slot_s;

   // one core-wide line, slot 0 in the low bits
   typedef struct packed {
      logic [`LRPF_LINE_SLOTS-1:0] ctl;
      logic [`LRPF_LINE_SLOTS*`LRPF_LINK_W-1:0] data;
   } lrpf_line_s;

endpackage

// file: core/lrpf_gray_sync.sv
// write pointer crossing: gray encode, two flop synchroniser, decode
// assumes bin_in comes from a flop of the writing side
`timescale 1ns/1ps

module lrpf_gray_sync import lrpf_pkg::*; #(
   parameter int W = 6
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // pointer in and out
   input wire logic [W-1:0] bin_in,
   output logic [W-1:0] bin_out
);

   logic [W-1:0] gray_q, gray_d;
   logic [W-1:0] meta_q, sync_q;

   // ***********************************************
   // encode and synchronise
   // ***********************************************
   // gray so a sample mid-change is off by one step at most
   always_comb begin
      gray_d = bin_in ^ (bin_in >> 1);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gray_q <= '0;
         meta_q <= '0;
         sync_q <= '0;
      end else if (clk_en) begin
         gray_q <= gray_d;
         meta_q <= gray_q;
         sync_q <= meta_q;
      end
   end

   // ***********************************************
   // decode
   // ***********************************************
   always_comb begin
      bin_out[W-1] = sync_q[W-1];
      for (int i = W - 2; i >= 0; i--) begin
         bin_out[i] = bin_out[i+1] ^ sync_q[i];
      end
   end

endmodule

// file: core/lrpf_freq_cap.sv
// receive frequency limit from the capability vector
// assumes capability and programmed code are quasi-static
`timescale 1ns/1ps
`include "lrpf_cfg.svh"

module lrpf_freq_cap import lrpf_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // configuration
   input wire logic [`LRPF_CAP_W-1:0] freq_capability,
   input wire logic [`LRPF_FREQ_W-1:0] programmed_link_frequency,
   // results
   output logic [`LRPF_FREQ_W-1:0] max_rx_freq_q,
   output logic freq_violation_q
);

   logic [`LRPF_FREQ_W-1:0] max_rx_freq_d;
   logic freq_violation_d;

   // ***********************************************
   // highest advertised code and the limit check
   // ***********************************************
   // empty vector counts as a violation: no safe rate exists
   always_comb begin
      max_rx_freq_d = '0;
      for (int i = 0; i < `LRPF_CAP_W; i++) begin
         if (freq_capability[i]) begin
            max_rx_freq_d = `LRPF_FREQ_W'(i);
         end
      end
      freq_violation_d = (freq_capability == '0)
         || (programmed_link_frequency > max_rx_freq_d);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         max_rx_freq_q <= '0;
         freq_violation_q <= 1'b0;
      end else if (clk_en) begin
         max_rx_freq_q <= max_rx_freq_d;
         freq_violation_q <= freq_violation_d;
      end
   end

endmodule

// file: core/lrpf_rx_phase_fifo.sv
// receive phase recovery fifo: link slots in, core-wide lines out
// assumes link inputs are synchronous to clk and toggle at most once a cycle
// assumes the far side holds its lines steady while clk_en is low
`timescale 1ns/1ps
`include "lrpf_cfg.svh"

module lrpf_rx_phase_fifo import lrpf_pkg::*; #(
   parameter int DEPTH = `LRPF_DEPTH
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // link side
   input wire logic forwarded_clock_input,
   input wire logic [`LRPF_LINK_W-1:0] incoming_command_data_lines,
   input wire logic incoming_control_line,
   // configuration
   input wire lrpf_mode_e clocking_mode,
   input wire logic [`LRPF_FREQ_W-1:0] programmed_link_frequency,
   input wire logic [`LRPF_CAP_W-1:0] freq_capability,
   input wire logic link_init,
   // core side
   input wire logic core_read_tick,
   output lrpf_line_s line_q,
   output logic line_valid_q,
   // status
   output logic init_done_q,
   output logic slip_hold_q,
   output logic underrun_q,
   output logic overrun_q,
   output logic mode_full_q,
   output logic [`LRPF_FREQ_W-1:0] max_rx_freq_q,
   output logic freq_violation_q
);

   localparam int AW = $clog2(DEPTH);
   localparam int LINE = `LRPF_LINE_SLOTS;
   // each term of the write-to-read budget, in transmit-rate slots
   localparam int DRIFT_I = 2 * `LRPF_DRIFT_SLOTS;
   localparam int SKEW_I = `LRPF_SKEW_CONST_SLOTS + `LRPF_SKEW_VAR_SLOTS;
   // one core clock of sampling error is one whole line of slots
   localparam int SAMPLE_I = `LRPF_SAMPLE_ERR_RCLK * LINE;
   // seven more slots so a full line is written before it is read
   localparam int FILL_I = LINE - 1;
   localparam int SEP_I = DRIFT_I + SKEW_I + SAMPLE_I + FILL_I;
   localparam logic [AW-1:0] WR2RD_SEP = AW'(SEP_I);
   localparam logic [AW-1:0] SYNC_COMP = AW'(`LRPF_SYNC_COMP_SLOTS);
   localparam logic [AW-1:0] LINE_A = AW'(LINE);
   // read-to-overwrite margin mirrors the write-to-read one
   localparam logic [AW-1:0] OVR_LIMIT = AW'(DEPTH - SEP_I);

   // ***********************************************
   // write side
   // ***********************************************
   lrpf_slot_s mem [DEPTH];
   lrpf_slot_s slot_in;
   logic fclk_q, fclk_d;
   logic [AW-1:0] wr_q, wr_d;
   logic wr_ev;

   // pack the link lines into one slot
   always_comb begin
      slot_in.ctl = incoming_control_line;
      slot_in.data = incoming_command_data_lines;
   end

   // each forwarded clock transition carries one slot (double data rate)
   always_comb begin
      fclk_d = forwarded_clock_input;
      wr_ev = forwarded_clock_input ^ fclk_q;
      wr_d = wr_q;
      if (link_init) begin
         wr_d = '0;
      end else if (wr_ev) begin
         wr_d = wr_q + AW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fclk_q <= 1'b0;
         wr_q <= '0;
      end else if (clk_en) begin
         fclk_q <= fclk_d;
         wr_q <= wr_d;
      end
   end

   // storage is not reset; pointers alone decide what is valid
   always_ff @(posedge clk) begin
      if (clk_en && wr_ev && !link_init) begin
         mem[wr_q] <= slot_in;
      end
   end

   // ***********************************************
   // pointer crossing and frequency check
   // ***********************************************
   logic [AW-1:0] wr_seen;

   lrpf_gray_sync #(
      .W(AW)
   ) u_wr_sync (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .bin_in(wr_q),
      .bin_out(wr_seen)
   );

   lrpf_freq_cap u_freq_cap (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .freq_capability(freq_capability),
      .programmed_link_frequency(programmed_link_frequency),
      .max_rx_freq_q(max_rx_freq_q),
      .freq_violation_q(freq_violation_q)
   );

   // ***********************************************
   // idle detection on the link lines
   // ***********************************************
   logic low_q, low_d;

   // one flop of sampling, part of the delay taken off the read pointer
   always_comb begin
      low_d = (incoming_command_data_lines == '0) && !incoming_control_line;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_q <= 1'b0;
      end else if (clk_en) begin
         low_q <= low_d;
      end
   end

   // ***********************************************
   // read side
   // ***********************************************
   lrpf_state_e st_q, st_d;
   lrpf_mode_e mode_q, mode_d;
   logic [AW-1:0] rd_q, rd_d;
   logic [AW-1:0] sep;
   lrpf_line_s gather, line_d;
   logic line_valid_d, init_done_d, slip_hold_d;
   logic underrun_d, overrun_d, mode_full_d;
   logic relaxed;
   logic place_go, hold_go, take_go;

   // gather the line that starts at the read pointer
   always_comb begin
      for (int i = 0; i < LINE; i++) begin
         gather.ctl[i] = mem[rd_q + AW'(i)].ctl;
         gather.data[i*`LRPF_LINK_W +: `LRPF_LINK_W] = mem[rd_q + AW'(i)].data;
      end
   end

   // ***********************************************
   // read decision
   // ***********************************************
   // one decision per enabled edge; a restart cancels every one of them
   always_comb begin
      sep = wr_seen - rd_q;
      // non-sync modes share one hold; 2000 ppm drift is far below one slip a line
      relaxed = (mode_q != LRPF_MODE_SYNC);
      place_go = 1'b0;
      hold_go = 1'b0;
      take_go = 1'b0;
      if (!link_init) begin
         if (st_q == LRPF_ST_ARMED) begin
            place_go = low_q;
         end
         if ((st_q == LRPF_ST_RUN) && core_read_tick) begin
            // sync mode relies on equal rates and never holds
            hold_go = relaxed && (sep < WR2RD_SEP);
            take_go = !hold_go;
         end
      end
   end

   // ***********************************************
   // pointer sequencing
   // ***********************************************
   // read pointer moves only at placement and by whole lines
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      rd_d = rd_q;
      init_done_d = init_done_q;
      case (st_q)
         LRPF_ST_IDLE: begin
            st_d = LRPF_ST_IDLE;
         end
         LRPF_ST_ARMED: begin
            if (place_go) begin
               // centred between both extremes of first-edge timing
               rd_d = wr_seen - WR2RD_SEP - SYNC_COMP;
               init_done_d = 1'b1;
               st_d = LRPF_ST_RUN;
            end
         end
         LRPF_ST_RUN: begin
            if (take_go) begin
               // no other adjustment, so sync mode keeps its placement
               rd_d = rd_q + LINE_A;
            end
         end
         default: begin
            st_d = LRPF_ST_IDLE;
         end
      endcase
      // restart wins over everything, from any state
      if (link_init) begin
         st_d = LRPF_ST_ARMED;
         mode_d = clocking_mode;
         init_done_d = 1'b0;
      end
   end

   // mode is captured only at restart, never in mid-run
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= LRPF_ST_IDLE;
         mode_q <= LRPF_MODE_SYNC;
         rd_q <= '0;
         init_done_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         mode_q <= mode_d;
         rd_q <= rd_d;
         init_done_q <= init_done_d;
      end
   end

   // ***********************************************
   // line register
   // ***********************************************
   // loaded on a taken read; both pulses last one enabled cycle
   always_comb begin
      line_d = line_q;
      line_valid_d = take_go;
      slip_hold_d = hold_go;
      if (take_go) begin
         line_d = gather;
      end
   end

   // line stays until the next taken read
   always_ff @(posedge clk) begin
      if (rst) begin
         line_q <= '0;
         line_valid_q <= 1'b0;
         slip_hold_q <= 1'b0;
      end else if (clk_en) begin
         line_q <= line_d;
         line_valid_q <= line_valid_d;
         slip_hold_q <= slip_hold_d;
      end
   end

   // ***********************************************
   // status flags
   // ***********************************************
   // sticky until restart; a restart cancels the read, so no set can race it
   always_comb begin
      underrun_d = underrun_q;
      overrun_d = overrun_q;
      mode_full_d = mode_full_q;
      if (take_go && (sep < LINE_A)) begin
         underrun_d = 1'b1;
      end
      if (take_go && (sep > OVR_LIMIT)) begin
         overrun_d = 1'b1;
      end
      if (link_init) begin
         mode_full_d = (clocking_mode == LRPF_MODE_SYNC);
         underrun_d = 1'b0;
         overrun_d = 1'b0;
      end
   end

   // flags only register here
   always_ff @(posedge clk) begin
      if (rst) begin
         underrun_q <= 1'b0;
         overrun_q <= 1'b0;
         mode_full_q <= 1'b0;
      end else if (clk_en) begin
         underrun_q <= underrun_d;
         overrun_q <= overrun_d;
         mode_full_q <= mode_full_d;
      end
   end

endmodule

// file: dv/lrpf_props.sv
// port checker for the receive phase fifo
// assumes it is bound onto lrpf_rx_phase_fifo; rst is synchronous
`timescale 1ns/1ps
`include "lrpf_cfg.svh"

module lrpf_props import lrpf_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // inputs
   input wire logic [`LRPF_LINK_W-1:0] incoming_command_data_lines,
   input wire logic incoming_control_line,
   input wire logic [`LRPF_FREQ_W-1:0] programmed_link_frequency,
   input wire logic [`LRPF_CAP_W-1:0] freq_capability,
   input wire logic link_init,
   input wire logic core_read_tick,
   // outputs
   input wire logic line_valid_q,
   input wire logic init_done_q,
   input wire logic slip_hold_q,
   input wire logic underrun_q,
   input wire logic overrun_q,
   input wire logic mode_full_q,
   input wire logic [`LRPF_FREQ_W-1:0] max_rx_freq_q,
   input wire logic freq_violation_q
);
   // ****
   // assertions
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // highest advertised code, 0 when none
   function automatic logic [`LRPF_FREQ_W-1:0] hi(input logic [`LRPF_CAP_W-1:0] c);
      hi = '0;
      for (int i = 0; i < `LRPF_CAP_W; i++) begin
         if (c[i])
            hi = i[`LRPF_FREQ_W-1:0];
      end
   endfunction
   // a read tick that is not overridden by a restart
   wire rd_ok = clk_en && core_read_tick && !link_init;
   read_answer_a: assert property (rd_ok && init_done_q |=> line_valid_q || slip_hold_q)
      else $error("read tick got no answer");
   idle_read_a: assert property (rd_ok && !init_done_q |=> !line_valid_q && !slip_hold_q)
      else $error("read answered before placement");
   sync_hold_a: assert property (mode_full_q |-> !slip_hold_q)
      else $error("hold seen in synchronous mode");
   init_clear_a: assert property (clk_en && link_init |=> !init_done_q && !underrun_q && !overrun_q)
      else $error("restart left state behind");
   init_low_a: assert property ($rose(init_done_q) |->
      $past(incoming_control_line, 2) == 1'b0 && $past(incoming_command_data_lines, 2) == '0)
      else $error("pointer placed without idle lines");
   flag_sticky_a: assert property ($fell(underrun_q) || $fell(overrun_q) |-> $past(link_init))
      else $error("flag dropped without restart");
   flag_cause_a: assert property ($rose(underrun_q) || $rose(overrun_q) |-> line_valid_q)
      else $error("flag rose without a line");
   freq_max_a: assert property (clk_en |=> max_rx_freq_q == hi($past(freq_capability)))
      else $error("wrong receive maximum");
   freq_viol_a: assert property (clk_en |=> freq_violation_q ==
      ($past(freq_capability) == '0 || $past(programmed_link_frequency) > hi($past(freq_capability))))
      else $error("wrong frequency violation");
   // main scenarios reached
   cover property (line_valid_q);
   cover property (slip_hold_q);
   cover property ($rose(underrun_q));
   cover property ($rose(overrun_q));
endmodule

bind lrpf_rx_phase_fifo lrpf_props u_props (.clk(clk), .rst(rst), .clk_en(clk_en),
   .incoming_command_data_lines(incoming_command_data_lines),
   .incoming_control_line(incoming_control_line),
   .programmed_link_frequency(programmed_link_frequency), .freq_capability(freq_capability),
   .link_init(link_init), .core_read_tick(core_read_tick), .line_valid_q(line_valid_q),
   .init_done_q(init_done_q), .slip_hold_q(slip_hold_q), .underrun_q(underrun_q),
   .overrun_q(overrun_q), .mode_full_q(mode_full_q), .max_rx_freq_q(max_rx_freq_q),
   .freq_violation_q(freq_violation_q));

// file: dv/lrpf_link_tx.sv
// remote transmitter model: forwarded clock, control and data
// assumes the core clock as common time base; idle lines sit low
`timescale 1ns/1ps
`include "lrpf_cfg.svh"

module lrpf_link_tx (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic [1:0] gap,
   input wire logic [7:0] base,
   // link lines
   output logic fclk,
   output logic [`LRPF_LINK_W-1:0] data,
   output logic ctl
);
   // ****
   // slot sender
   // ****
   logic [7:0] cnt;
   logic [1:0] wait_n;
   // one slot per gap cycles, four when gap is 0; the clock stands still when idle
   always @(posedge clk) begin
      if (rst) begin
         {fclk, cnt, wait_n, data, ctl} <= '0;
      end else if (!en) begin
         data <= '0; // low lines mark start-up
         ctl <= 1'b0;
      end else if (wait_n == 2'h0) begin
         fclk <= ~fclk;
         cnt <= cnt + 8'h01;
         data <= cnt ^ base;
         ctl <= cnt[0] ^ base[7];
         wait_n <= gap - 2'h1;
      end else begin
         wait_n <= wait_n - 2'h1;
      end
   end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the receive phase fifo
// assumes core/ on the include path and the package compiled first
`timescale 1ns/1ps
`include "lrpf_cfg.svh"

module tb_top import lrpf_pkg::*; ;
   // ****
   // signals, model state
   // ****
   logic clk, rst, clk_en, fclk, ctl, link_init, tick, en, ld, dn, sh, ur, ov, mf, fv;
   logic [7:0] data, base;
   logic [1:0] gap;
   lrpf_mode_e mode;
   logic [3:0] plf, mx, e_x;
   logic [15:0] cap;
   lrpf_line_s lq, e_l;
   integer seed = 32'hcea3d177;
   int fail_count = 0;
   int cmp_count = 0;
   lrpf_slot_s mem [64];
   bit wv [64];
   logic [5:0] wr, h1, h2, h3, ws, rd, sep;
   logic run, armed, low, pf, e_v, e_h, e_u, e_o, e_m, e_f, known;
   // cases: mode, slot gap, tick period
   logic [1:0] mt [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
   logic [1:0] gt [7] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1};
   int pr [7] = '{8, 3, 3, 6, 4, 30, 8};

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   lrpf_rx_phase_fifo u_lrpf_rx_phase_fifo (.clk(clk), .rst(rst), .clk_en(clk_en),
      .forwarded_clock_input(fclk), .incoming_command_data_lines(data),
      .incoming_control_line(ctl), .clocking_mode(mode), .programmed_link_frequency(plf),
      .freq_capability(cap), .link_init(link_init), .core_read_tick(tick), .line_q(lq),
      .line_valid_q(ld), .init_done_q(dn), .slip_hold_q(sh), .underrun_q(ur),
      .overrun_q(ov), .mode_full_q(mf), .max_rx_freq_q(mx), .freq_violation_q(fv));
   lrpf_link_tx u_lrpf_link_tx (.clk(clk), .rst(rst), .en(en), .gap(gap), .base(base),
      .fclk(fclk), .data(data), .ctl(ctl));

   // highest advertised code
   function automatic logic [3:0] hi(input logic [15:0] c);
      hi = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (c[i])
            hi = 4'(i);
      end
   endfunction

   task automatic chk(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****
   // reference model, one step per enabled edge
   // ****
   always @(posedge clk) begin
      if (rst) begin
         {wr, h1, h2, h3, rd, run, armed, low, pf, e_v, e_h, e_u, e_o, e_m, e_f, e_x} = '0;
      end else if (clk_en) begin
         // gray register plus two synchroniser flops: three enabled edges of lag
         ws = h3;
         h3 = h2;
         h2 = h1;
         h1 = wr;
         {e_v, e_h} = 2'b00;
         e_x = hi(cap);
         e_f = (cap == 16'h0000) || (plf > hi(cap));
         if (link_init) begin
            {run, e_u, e_o, wr} = '0;
            armed = 1'b1;
            e_m = (mode == LRPF_MODE_SYNC);
         end else if (armed && low) begin
            rd = ws - 6'h17;
            run = 1'b1;
            armed = 1'b0;
         end else if (run && tick) begin
            sep = ws - rd;
            if (!e_m && sep < 6'h15)
               e_h = 1'b1;
            else begin
               e_v = 1'b1;
               e_u |= sep < 6'h08;
               e_o |= sep > 6'h2B;
               known = 1'b1;
               for (int i = 0; i < 8; i++) begin
                  known &= wv[6'(rd + i)];
                  e_l.data[8*i +: 8] = mem[6'(rd + i)].data;
                  e_l.ctl[i] = mem[6'(rd + i)].ctl;
               end
               rd = rd + 6'h08;
            end
         end
         // old contents are read before this edge's write lands
         if (fclk != pf && !link_init) begin
            mem[wr] = '{ctl, data};
            wv[wr] = 1'b1;
            wr = wr + 6'h01;
         end
         pf = fclk;
         low = (data == 8'h00) && !ctl;
      end
   end

   // mid-cycle comparison, outputs settled
   always @(negedge clk) begin
      if (!rst) begin
         chk(ld === e_v, "line valid");
         chk(sh === e_h, "slip hold");
         chk(dn === run, "placement");
         chk(ur === e_u && ov === e_o, "flags");
         chk(mf === e_m, "mode");
         chk(mx === e_x && fv === e_f, "frequency limit");
         if (e_v && known)
            chk(lq === e_l, "line data");
      end
   end

   // ****
   // stimulus
   // ****
   task automatic run_case(input int k);
      @(posedge clk);
      mode <= lrpf_mode_e'(mt[k]);
      gap <= gt[k];
      base <= 8'($random(seed));
      cap <= (k == 0) ? 16'h0000 : 16'h8000 >> k;
      plf <= 4'(k * 3);
      en <= (k == 6); // lines busy at start-up in case 6 only
      link_init <= 1'b1;
      repeat (4) @(posedge clk);
      link_init <= 1'b0;
      en <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(dn === 1'b1, "not placed after idle lines");
      @(posedge clk);
      en <= 1'b1;
      repeat (400) begin
         @(posedge clk);
         tick <= ({$random(seed)} % pr[k]) == 0;
         clk_en <= ({$random(seed)} % 16) != 0;
         if ({$random(seed)} % 64 == 0)
            {cap, plf} <= 20'($random(seed));
      end
      @(posedge clk);
      {tick, en, clk_en} <= 3'b001;
      $display("test %0d done", k);
   endtask

   initial begin
      {rst, clk_en, link_init, tick, en} = 5'b11000;
      gap = 2'h1;
      base = 8'h00;
      mode = LRPF_MODE_SYNC;
      {plf, cap} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 7; k++)
         run_case(k);
      wrap_up();
   end

   // cases take about 3000 cycles; twice that means a hang
   initial begin
      repeat (6000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule
